// file: verilog/pisc_top.v
// Purpose: port config, global enables and per-slot tables behind apb
// Assumes: one clock pclk at 250 MHz, strap pin is asynchronous
// Notes: slot tables are plain flip-flops and keep their content over reset
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "pisc_defines.vh"
// What this block does
// - every register except the slot tables takes its default value when reset asserts.
// - slot tables are never cleared by reset; content undefined until written.
// - global bits switch cell-bus receive and transmit interfaces on.
// - port-type bit, 1 cell transport, 0 adaptation-layer emulation.
// - adaptation mode with structure bit 1 means unstructured emulation.
// - adaptation mode with structure bit 0 means structured n x 64 service.
// - two independent bits choose adaptive and timestamp clock recovery.
// - global recovery interface enable and 4-bit substitute timestamp, default 0.
// - programmable alpha, delta and coset for cell delineation.
// - cells matching drop pattern under drop mask are deleted.
// - filler cells use programmable header and payload octets.
// - threshold word: active flag in top bit, value in low bits.
// - oam timers have enable and count in 245 us units.
// - slot entries: zero idle, reference flag, continuation names reference.
// - cell receive reference: ocd interrupts, hunt, idle deletion, descramble.
// - cell transmit reference holds the payload scramble enable.
// - adaptation receive reference: next slot, seed and fill fields.
// - adaptation transmit reference: sequence checks, sync loss, reinit trigger.
// - extension entry: starvation count, logical size, auto reinit flags.
// - unstructured mode reassembly buffer holds 256 cells per port.
// - global bit enables output queue overflow counting.
module pisc_top #(
  parameter PORTS = 8,
  parameter [15:0] VERSION_CODE = 16'h0A5A,
  parameter TICK_CYCLES = (`PISC_TICK_NS + `PISC_CLK_NS - 1) / `PISC_CLK_NS
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire e1_strap,
  input wire [2:0] lookup_port,
  input wire [4:0] lookup_slot,
  input wire [31:0] ext_word,
  output reg cellbus_receive_en,
  output reg cellbus_transmit_en,
  output reg crv_if_en,
  output reg ovf_count_en,
  output reg [3:0] substitute_rts,
  output reg [3:0] delin_alpha,
  output reg [3:0] delin_delta,
  output reg [7:0] delin_coset,
  output reg [7:0] drop_header_pattern,
  output reg [7:0] drop_header_mask,
  output reg [7:0] filler_header_octet,
  output reg [7:0] filler_payload_octet,
  output reg [PORTS-1:0] port_cell_mode,
  output reg [PORTS-1:0] port_unstructured,
  output reg [PORTS-1:0] port_structured,
  output reg [PORTS-1:0] port_adaptive,
  output reg [PORTS-1:0] port_timestamp,
  output reg [PORTS-1:0] port_tx_active,
  output reg [PORTS-1:0] port_rx_active,
  output reg [PORTS-1:0] buffer_reinit_pulse,
  output reg rx_slot_live,
  output reg tx_slot_live,
  output reg [31:0] rx_ref_entry,
  output reg [31:0] tx_ref_entry,
  output reg [31:0] tx_ext_entry,
  output reg payload_descramble_en,
  output reg payload_scramble_en,
  output reg ocd_start_irq_en,
  output reg ocd_end_irq_en,
  output reg hunt_force,
  output reg idle_delete_en,
  output reg [4:0] following_slot_index,
  output reg [4:0] decorrelator_seed,
  output reg [5:0] cell_fill_count,
  output reg seq_number_check_en,
  output reg seq_fast_algorithm,
  output reg [1:0] structure_sync_loss_limit,
  output reg reinit_on_overflow,
  output reg reinit_on_underflow,
  output reg [10:0] starvation_count,
  output reg [13:0] logical_buffer_size,
  output reg threshold_active,
  output reg [15:0] threshold_value,
  output reg timer_enable,
  output reg [15:0] timer_value,
  output reg oam_tick
);
  localparam SLOTS = PORTS * 32;
  reg [31:0] receive_slot_table [0:SLOTS-1];
  reg [31:0] transmit_slot_table [0:SLOTS-1];
  reg [31:0] transmit_slot_extension [0:SLOTS-1];
  reg [5:0] port_config_reg [0:PORTS-1];
  reg [7:0] global_cfg;
  reg [15:0] delin_cfg;
  reg [15:0] drop_cfg;
  reg [15:0] filler_cfg;
  reg strap_meta;
  reg strap_sync;
  reg [31:0] tick_count;
  reg [31:0] next_prdata;
  reg next_pslverr;
  wire setup = psel & ~penable;
  wire wr_go = psel & penable & pready & pwrite & ~pslverr;
  wire [1:0] tbl_sel = paddr[11:10];
  wire [7:0] tbl_idx = paddr[9:2];
  wire port_hit = (paddr[11:5] == `PISC_A_PORT) && (paddr[4:2] < PORTS);
  wire [2:0] port_idx = paddr[4:2];
  wire [7:0] look_idx = {lookup_port, lookup_slot};
  wire [31:0] rx_e = receive_slot_table[look_idx];
  wire [31:0] tx_e = transmit_slot_table[look_idx];
  wire [7:0] rx_ref_idx = {lookup_port, rx_e[`PISC_E_OWNER]};
  wire [7:0] tx_ref_idx = {lookup_port, tx_e[`PISC_E_OWNER]};
  reg [31:0] rx_ref;
  reg [31:0] tx_ref;
  reg [31:0] tx_x;
  reg rx_go;
  reg tx_go;
  reg [5:0] pc_look;
  integer i;
  integer j;

  // continuation entries follow their owning reference entry
  always @* begin
    rx_ref = 32'h0000_0000;
    tx_ref = 32'h0000_0000;
    tx_x = 32'h0000_0000;
    if (rx_e[`PISC_E_REF]) begin
      rx_ref = rx_e;
    end else if (rx_e[`PISC_E_CONT]) begin
      rx_ref = receive_slot_table[rx_ref_idx];
    end
    if (tx_e[`PISC_E_REF]) begin
      tx_ref = tx_e;
      tx_x = transmit_slot_extension[look_idx];
    end else if (tx_e[`PISC_E_CONT]) begin
      tx_ref = transmit_slot_table[tx_ref_idx];
      tx_x = transmit_slot_extension[tx_ref_idx];
    end
    pc_look = port_config_reg[lookup_port];
    // idle or inactive slots carry no payload
    rx_go = rx_ref[`PISC_E_REF] && (rx_ref[`PISC_E_STATE] == `PISC_STATE_ACTIVE)
      && pc_look[`PISC_P_RX_ACT] && global_cfg[`PISC_G_RX_EN];
    tx_go = tx_ref[`PISC_E_REF] && (tx_ref[`PISC_E_STATE] == `PISC_STATE_ACTIVE)
      && pc_look[`PISC_P_TX_ACT] && global_cfg[`PISC_G_TX_EN];
  end

  // read data is prepared in the setup cycle so prdata can be a flop
  always @* begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (tbl_sel == `PISC_A_TBL_RX) begin
      next_prdata = receive_slot_table[tbl_idx];
    end else if (tbl_sel == `PISC_A_TBL_TX) begin
      next_prdata = transmit_slot_table[tbl_idx];
    end else if (tbl_sel == `PISC_A_TBL_EXT) begin
      next_prdata = transmit_slot_extension[tbl_idx];
    end else if (port_hit) begin
      next_prdata = {26'h0, port_config_reg[port_idx]};
    end else begin
      case (paddr)
        `PISC_A_VERSION: next_prdata = {6'h0, `PISC_BUF_CELLS, strap_sync, VERSION_CODE};
        `PISC_A_GLOBAL: next_prdata = {24'h0, global_cfg};
        `PISC_A_DELIN: next_prdata = {16'h0, delin_cfg};
        `PISC_A_DROP: next_prdata = {16'h0, drop_cfg};
        `PISC_A_FILLER: next_prdata = {16'h0, filler_cfg};
        default: next_pslverr = 1'b1;
      endcase
    end
    if (next_pslverr && pwrite) begin
      next_prdata = 32'h0000_0000;
    end
  end

  // tables sit outside the reset net on purpose
  always @(posedge pclk) begin
    if (wr_go && (tbl_sel == `PISC_A_TBL_RX)) begin
      receive_slot_table[tbl_idx] <= pwdata;
    end
    if (wr_go && (tbl_sel == `PISC_A_TBL_TX)) begin
      transmit_slot_table[tbl_idx] <= pwdata;
    end
    if (wr_go && (tbl_sel == `PISC_A_TBL_EXT)) begin
      transmit_slot_extension[tbl_idx] <= pwdata;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      strap_meta <= 1'b0;
      strap_sync <= 1'b0;
      global_cfg <= `PISC_RST_GLOBAL;
      delin_cfg <= `PISC_RST_DELIN;
      drop_cfg <= `PISC_RST_DROP;
      filler_cfg <= `PISC_RST_FILLER;
      for (j = 0; j < PORTS; j = j + 1) begin
        port_config_reg[j] <= `PISC_RST_PORT;
      end
      buffer_reinit_pulse <= {PORTS{1'b0}};
    end else begin
      strap_meta <= e1_strap;
      strap_sync <= strap_meta;
      pready <= setup;
      if (setup) begin
        prdata <= next_prdata;
        pslverr <= next_pslverr;
      end
      buffer_reinit_pulse <= {PORTS{1'b0}};
      if (wr_go && (tbl_sel == `PISC_A_TBL_TX) && pwdata[`PISC_E_REF]
          && pwdata[`PISC_TX_REINIT]) begin
        buffer_reinit_pulse[tbl_idx[7:5]] <= 1'b1;
      end
      if (wr_go && port_hit) begin
        port_config_reg[port_idx] <= pwdata[5:0];
      end
      if (wr_go && (paddr == `PISC_A_GLOBAL)) begin
        global_cfg <= pwdata[7:0];
      end
      if (wr_go && (paddr == `PISC_A_DELIN)) begin
        delin_cfg <= pwdata[15:0];
      end
      if (wr_go && (paddr == `PISC_A_DROP)) begin
        drop_cfg <= pwdata[15:0];
      end
      if (wr_go && (paddr == `PISC_A_FILLER)) begin
        filler_cfg <= pwdata[15:0];
      end
    end
  end

  // configuration fan-out, one flop stage behind the registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cellbus_receive_en <= 1'b0;
      cellbus_transmit_en <= 1'b0;
      crv_if_en <= 1'b0;
      ovf_count_en <= 1'b0;
      substitute_rts <= 4'h0;
      delin_alpha <= 4'h0;
      delin_delta <= 4'h0;
      delin_coset <= 8'h00;
      drop_header_pattern <= 8'h00;
      drop_header_mask <= 8'h00;
      filler_header_octet <= 8'h00;
      filler_payload_octet <= 8'h00;
      port_cell_mode <= {PORTS{1'b0}};
      port_unstructured <= {PORTS{1'b0}};
      port_structured <= {PORTS{1'b0}};
      port_adaptive <= {PORTS{1'b0}};
      port_timestamp <= {PORTS{1'b0}};
      port_tx_active <= {PORTS{1'b0}};
      port_rx_active <= {PORTS{1'b0}};
    end else begin
      cellbus_receive_en <= global_cfg[`PISC_G_RX_EN];
      cellbus_transmit_en <= global_cfg[`PISC_G_TX_EN];
      crv_if_en <= global_cfg[`PISC_G_CRV_EN];
      substitute_rts <= global_cfg[`PISC_G_RTS];
      ovf_count_en <= global_cfg[`PISC_G_OVF_EN];
      delin_alpha <= delin_cfg[15:12];
      delin_delta <= delin_cfg[11:8];
      delin_coset <= delin_cfg[7:0];
      drop_header_pattern <= drop_cfg[15:8];
      drop_header_mask <= drop_cfg[7:0];
      filler_header_octet <= filler_cfg[15:8];
      filler_payload_octet <= filler_cfg[7:0];
      for (i = 0; i < PORTS; i = i + 1) begin
        port_cell_mode[i] <= port_config_reg[i][`PISC_P_CELL];
        port_unstructured[i] <= ~port_config_reg[i][`PISC_P_CELL]
          & port_config_reg[i][`PISC_P_UNSTR];
        port_structured[i] <= ~port_config_reg[i][`PISC_P_CELL]
          & ~port_config_reg[i][`PISC_P_UNSTR];
        port_adaptive[i] <= port_config_reg[i][`PISC_P_ADAPT];
        port_timestamp[i] <= port_config_reg[i][`PISC_P_STAMP];
        port_tx_active[i] <= port_config_reg[i][`PISC_P_TX_ACT];
        port_rx_active[i] <= port_config_reg[i][`PISC_P_RX_ACT];
      end
    end
  end

  // slot lookup: fields are zero unless the slot group is live
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_slot_live <= 1'b0;
      tx_slot_live <= 1'b0;
      rx_ref_entry <= 32'h0000_0000;
      tx_ref_entry <= 32'h0000_0000;
      tx_ext_entry <= 32'h0000_0000;
      payload_descramble_en <= 1'b0;
      payload_scramble_en <= 1'b0;
      ocd_start_irq_en <= 1'b0;
      ocd_end_irq_en <= 1'b0;
      hunt_force <= 1'b0;
      idle_delete_en <= 1'b0;
      following_slot_index <= 5'h00;
      decorrelator_seed <= 5'h00;
      cell_fill_count <= 6'h00;
      seq_number_check_en <= 1'b0;
      seq_fast_algorithm <= 1'b0;
      structure_sync_loss_limit <= 2'h0;
      reinit_on_overflow <= 1'b0;
      reinit_on_underflow <= 1'b0;
      starvation_count <= 11'h000;
      logical_buffer_size <= 14'h0000;
    end else begin
      rx_slot_live <= rx_go;
      tx_slot_live <= tx_go;
      rx_ref_entry <= rx_go ? rx_ref : 32'h0000_0000;
      tx_ref_entry <= tx_go ? tx_ref : 32'h0000_0000;
      tx_ext_entry <= tx_go ? tx_x : 32'h0000_0000;
      // cell-mode receive fields and the transmit scramble enable
      payload_descramble_en <= rx_go & pc_look[`PISC_P_CELL] & rx_ref[`PISC_RX_DESCR];
      ocd_start_irq_en <= rx_go & pc_look[`PISC_P_CELL] & rx_ref[`PISC_RX_OCD_START];
      ocd_end_irq_en <= rx_go & pc_look[`PISC_P_CELL] & rx_ref[`PISC_RX_OCD_END];
      hunt_force <= rx_go & pc_look[`PISC_P_CELL] & rx_ref[`PISC_RX_HUNT];
      idle_delete_en <= rx_go & pc_look[`PISC_P_CELL] & rx_ref[`PISC_RX_DEL_IDLE];
      payload_scramble_en <= tx_go & pc_look[`PISC_P_CELL] & tx_ref[`PISC_TX_SCR];
      // adaptation-layer fields, only meaningful outside cell mode
      if (rx_go && !pc_look[`PISC_P_CELL]) begin
        following_slot_index <= rx_ref[`PISC_E_NEXT];
        decorrelator_seed <= rx_ref[`PISC_RX_SEED];
        cell_fill_count <= rx_ref[`PISC_RX_FILL];
      end else begin
        following_slot_index <= 5'h00;
        decorrelator_seed <= 5'h00;
        cell_fill_count <= 6'h00;
      end
      if (tx_go && !pc_look[`PISC_P_CELL]) begin
        seq_number_check_en <= tx_ref[`PISC_TX_SN_CHK];
        seq_fast_algorithm <= tx_ref[`PISC_TX_FAST];
        structure_sync_loss_limit <= tx_ref[`PISC_TX_OOS];
        reinit_on_overflow <= tx_x[`PISC_X_OF];
        reinit_on_underflow <= tx_x[`PISC_X_UF];
        starvation_count <= tx_x[`PISC_X_STARV];
        logical_buffer_size <= tx_x[`PISC_X_LSIZE];
      end else begin
        seq_number_check_en <= 1'b0;
        seq_fast_algorithm <= 1'b0;
        structure_sync_loss_limit <= 2'h0;
        reinit_on_overflow <= 1'b0;
        reinit_on_underflow <= 1'b0;
        starvation_count <= 11'h000;
        logical_buffer_size <= 14'h0000;
      end
    end
  end

  // external threshold/timer word decode and 245 us oam tick
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      threshold_active <= 1'b0;
      threshold_value <= 16'h0000;
      timer_enable <= 1'b0;
      timer_value <= 16'h0000;
      tick_count <= 32'h0000_0000;
      oam_tick <= 1'b0;
    end else begin
      threshold_active <= ext_word[`PISC_W_FLAG];
      threshold_value <= ext_word[`PISC_W_VALUE];
      timer_enable <= ext_word[`PISC_W_FLAG];
      timer_value <= ext_word[`PISC_W_VALUE];
      if (tick_count >= TICK_CYCLES - 1) begin
        tick_count <= 32'h0000_0000;
        oam_tick <= 1'b1;
      end else begin
        tick_count <= tick_count + 32'h0000_0001;
        oam_tick <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: common/pisc_defines.vh
// Purpose: shared constants for the port init and slot config block
// Assumes: byte addresses on a 12-bit apb address
// Notes: field positions follow the slot entry word layout
`ifndef PISC_DEFINES_VH
`define PISC_DEFINES_VH
`define PISC_A_VERSION 12'h000
`define PISC_A_GLOBAL 12'h004
`define PISC_A_DELIN 12'h008
`define PISC_A_DROP 12'h00C
`define PISC_A_FILLER 12'h010
`define PISC_A_PORT 7'h01
`define PISC_A_TBL_RX 2'h1
`define PISC_A_TBL_TX 2'h2
`define PISC_A_TBL_EXT 2'h3
`define PISC_RST_GLOBAL 8'h00
`define PISC_RST_DELIN 16'h7655
`define PISC_RST_DROP 16'h0100
`define PISC_RST_FILLER 16'h016A
`define PISC_RST_PORT 6'h00
`define PISC_G_RX_EN 0
`define PISC_G_TX_EN 1
`define PISC_G_CRV_EN 2
`define PISC_G_OVF_EN 3
`define PISC_G_RTS 7:4
`define PISC_P_CELL 0
`define PISC_P_UNSTR 1
`define PISC_P_ADAPT 2
`define PISC_P_STAMP 3
`define PISC_P_TX_ACT 4
`define PISC_P_RX_ACT 5
`define PISC_E_REF 0
`define PISC_E_CONT 1
`define PISC_E_STATE 2:1
`define PISC_E_OWNER 6:2
`define PISC_E_NEXT 31:27
`define PISC_STATE_ACTIVE 2'h1
`define PISC_RX_DESCR 3
`define PISC_RX_DEL_IDLE 4
`define PISC_RX_HUNT 5
`define PISC_RX_OCD_END 6
`define PISC_RX_OCD_START 7
`define PISC_RX_SEED 20:16
`define PISC_RX_FILL 14:9
`define PISC_TX_SCR 3
`define PISC_TX_REINIT 16
`define PISC_TX_OOS 21:20
`define PISC_TX_FAST 23
`define PISC_TX_SN_CHK 24
`define PISC_X_UF 0
`define PISC_X_OF 1
`define PISC_X_LSIZE 15:2
`define PISC_X_STARV 26:16
`define PISC_W_FLAG 31
`define PISC_W_VALUE 15:0
`define PISC_TICK_NS 245000
`define PISC_CLK_NS 4
`define PISC_BUF_CELLS 9'h100
`endif

// file: sim/pisc_top_chk.sv
// Purpose: port-level assertions for pisc_top
// Assumes: one clock pclk, presetn async active low
// Notes: bound in, sees only the top ports
`timescale 1ns/1ps
`default_nettype none
module pisc_top_chk #(
  parameter TICK_CYCLES = 61250
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire [31:0] ext_word,
  input wire [3:0] delin_alpha,
  input wire [3:0] delin_delta,
  input wire [7:0] delin_coset,
  input wire [7:0] drop_header_pattern,
  input wire [7:0] drop_header_mask,
  input wire [7:0] filler_header_octet,
  input wire [7:0] filler_payload_octet,
  input wire cellbus_receive_en,
  input wire [7:0] port_cell_mode,
  input wire [7:0] port_unstructured,
  input wire [7:0] port_structured,
  input wire [7:0] buffer_reinit_pulse,
  input wire rx_slot_live,
  input wire tx_slot_live,
  input wire [31:0] rx_ref_entry,
  input wire [31:0] tx_ref_entry,
  input wire payload_descramble_en,
  input wire payload_scramble_en,
  input wire threshold_active,
  input wire [15:0] threshold_value,
  input wire oam_tick
);
  logic [1:0] up_cnt;
  logic [31:0] gap;
  logic had_tick;
  wire [16:0] ext_key = {ext_word[31], ext_word[15:0]};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // reset age and tick spacing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_cnt <= 2'h0;
      gap <= 32'h0;
      had_tick <= 1'b0;
    end else begin
      up_cnt <= (up_cnt == 2'h3) ? up_cnt : up_cnt + 2'h1;
      gap <= oam_tick ? 32'h0 : gap + 32'h1;
      had_tick <= had_tick | oam_tick;
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_hole;
    s_setup ##0 ((paddr >= 12'h014 && paddr < 12'h020) || (paddr >= 12'h040 && paddr < 12'h400));
  endsequence
  property p_ready_next; s_setup |=> pready; endproperty
  a_ready_next: assert property (p_ready_next) else $error("no answer after setup");
  property p_ready_one; pready |=> !pready; endproperty
  a_ready_one: assert property (p_ready_one) else $error("ready held too long");
  property p_refuse; s_hole |=> pslverr; endproperty
  a_refuse: assert property (p_refuse) else $error("unmapped access not refused");
  property p_defaults;
    up_cnt == 2'h1 |-> {delin_alpha, delin_delta, delin_coset} == 16'h7655
      && {drop_header_pattern, drop_header_mask} == 16'h0100
      && {filler_header_octet, filler_payload_octet} == 16'h016A && !cellbus_receive_en;
  endproperty
  a_defaults: assert property (p_defaults) else $error("bad value after reset");
  property p_mode_split; (port_unstructured & (port_cell_mode | port_structured)) == 8'h00;
  endproperty
  a_mode_split: assert property (p_mode_split) else $error("port mode overlap");
  property p_live_ref; rx_slot_live |-> rx_ref_entry[0] && rx_ref_entry[2:1] == 2'h1; endproperty
  a_live_ref: assert property (p_live_ref) else $error("live without active reference");
  property p_dead_zero; !rx_slot_live |-> rx_ref_entry == 32'h0 && !payload_descramble_en;
  endproperty
  a_dead_zero: assert property (p_dead_zero) else $error("fields leak from idle slot");
  property p_scramble; payload_scramble_en |-> tx_slot_live && tx_ref_entry[3]; endproperty
  a_scramble: assert property (p_scramble) else $error("scramble without its entry bit");
  property p_thresh; up_cnt == 2'h3 |-> {threshold_active, threshold_value} == $past(ext_key);
  endproperty
  a_thresh: assert property (p_thresh) else $error("threshold word split wrong");
  property p_reinit_one; |buffer_reinit_pulse |=> buffer_reinit_pulse == 8'h00; endproperty
  a_reinit_one: assert property (p_reinit_one) else $error("reinit pulse too long");
  property p_tick; oam_tick && had_tick |-> gap == TICK_CYCLES - 1; endproperty
  a_tick: assert property (p_tick) else $error("tick spacing wrong");
endmodule
bind pisc_top pisc_top_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.*);
`default_nettype wire

// file: sim/pisc_top_tb.sv
// Purpose: self-checking bench for pisc_top
// Assumes: apb master with one idle cycle between transfers
// Notes: tick period cut to 10 cycles for run length
`timescale 1ns/1ps
`default_nettype none
`define PISC_CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module pisc_top_tb;
  typedef struct packed {logic [11:0] a; logic [31:0] w; logic [31:0] r; logic e;} pisc_row_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, ext_word = 32'h0, prdata, rd_q, tx_ref_entry, tx_ext_entry;
  logic pready, pslverr, rd_e, rx_slot_live, tx_slot_live, crv_if_en, ovf_count_en;
  logic [2:0] lookup_port = 3'h0;
  logic [4:0] lookup_slot = 5'h00, following_slot_index, decorrelator_seed;
  logic cellbus_receive_en, cellbus_transmit_en, payload_descramble_en, payload_scramble_en;
  logic ocd_start_irq_en, ocd_end_irq_en, hunt_force, idle_delete_en, seq_number_check_en;
  logic seq_fast_algorithm, reinit_on_overflow, reinit_on_underflow, threshold_active;
  logic timer_enable, oam_tick;
  logic [3:0] substitute_rts, delin_alpha, delin_delta;
  logic [7:0] delin_coset, drop_header_pattern, drop_header_mask, filler_header_octet;
  logic [7:0] filler_payload_octet, port_cell_mode, port_unstructured, port_structured;
  logic [7:0] port_adaptive, port_timestamp, port_tx_active, port_rx_active;
  logic [7:0] buffer_reinit_pulse, reinit_seen, n_tick;
  logic [31:0] rx_ref_entry;
  logic [5:0] cell_fill_count, v;
  logic [1:0] structure_sync_loss_limit;
  logic [10:0] starvation_count;
  logic [13:0] logical_buffer_size;
  logic [15:0] threshold_value, timer_value;
  int failures = 0, checks_done = 0;
  pisc_row_t rows [0:7] = '{'{12'h004, 32'h5F, 32'h5F, 1'b0}, '{12'h008, 32'hA5C3, 32'hA5C3, 1'b0},
    '{12'h00C, 32'h01FE, 32'h01FE, 1'b0}, '{12'h010, 32'h1234, 32'h1234, 1'b0},
    '{12'h02C, 32'hFFFFFFFF, 32'h3F, 1'b0}, '{12'h014, 32'hFFFFFFFF, 32'h0, 1'b1},
    '{12'h3FC, 32'h12345678, 32'h0, 1'b1}, '{12'h000, 32'hFFFFFFFF, 32'h02010A5A, 1'b0}};
  logic [43:0] dflt [0:4] = '{{12'h004, 32'h0}, {12'h008, 32'h7655}, {12'h00C, 32'h0100},
    {12'h010, 32'h016A}, {12'h02C, 32'h0}};
  pisc_top #(.TICK_CYCLES(10)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .e1_strap(1'b1), .lookup_port(lookup_port),
    .lookup_slot(lookup_slot), .ext_word(ext_word), .cellbus_receive_en(cellbus_receive_en),
    .cellbus_transmit_en(cellbus_transmit_en), .crv_if_en(crv_if_en),
    .ovf_count_en(ovf_count_en), .substitute_rts(substitute_rts), .delin_alpha(delin_alpha),
    .delin_delta(delin_delta), .delin_coset(delin_coset),
    .drop_header_pattern(drop_header_pattern), .drop_header_mask(drop_header_mask),
    .filler_header_octet(filler_header_octet), .filler_payload_octet(filler_payload_octet),
    .port_cell_mode(port_cell_mode), .port_unstructured(port_unstructured),
    .port_structured(port_structured), .port_adaptive(port_adaptive),
    .port_timestamp(port_timestamp), .port_tx_active(port_tx_active),
    .port_rx_active(port_rx_active), .buffer_reinit_pulse(buffer_reinit_pulse),
    .rx_slot_live(rx_slot_live), .tx_slot_live(tx_slot_live), .rx_ref_entry(rx_ref_entry),
    .tx_ref_entry(tx_ref_entry), .tx_ext_entry(tx_ext_entry),
    .payload_descramble_en(payload_descramble_en), .payload_scramble_en(payload_scramble_en),
    .ocd_start_irq_en(ocd_start_irq_en), .ocd_end_irq_en(ocd_end_irq_en),
    .hunt_force(hunt_force), .idle_delete_en(idle_delete_en),
    .following_slot_index(following_slot_index), .decorrelator_seed(decorrelator_seed),
    .cell_fill_count(cell_fill_count), .seq_number_check_en(seq_number_check_en),
    .seq_fast_algorithm(seq_fast_algorithm),
    .structure_sync_loss_limit(structure_sync_loss_limit),
    .reinit_on_overflow(reinit_on_overflow), .reinit_on_underflow(reinit_on_underflow),
    .starvation_count(starvation_count), .logical_buffer_size(logical_buffer_size),
    .threshold_active(threshold_active), .threshold_value(threshold_value),
    .timer_enable(timer_enable), .timer_value(timer_value), .oam_tick(oam_tick));
  always #2 pclk = ~pclk;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) reinit_seen <= 8'h00;
    else reinit_seen <= reinit_seen | buffer_reinit_pulse;
  end
  task print_verdict();
    if (failures == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // idle cycle before each setup
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge pclk);
      n++;
    end
    rd_q = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      failures++;
      print_verdict();
    end
  endtask
  task settle();
    repeat (3) @(posedge pclk);
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].w);
      `PISC_CHK(rd_e, rows[i].e);
      apb(1'b0, rows[i].a, 32'h0);
      `PISC_CHK(rd_q, rows[i].r);
      `PISC_CHK(rd_e, rows[i].e);
    end
    settle();
    `PISC_CHK({cellbus_transmit_en, cellbus_receive_en}, 2'h3);
    `PISC_CHK({ovf_count_en, crv_if_en, substitute_rts}, 6'h35);
    `PISC_CHK({delin_alpha, delin_delta, delin_coset}, 16'hA5C3);
    `PISC_CHK({drop_header_pattern, drop_header_mask}, 16'h01FE);
    `PISC_CHK({filler_header_octet, filler_payload_octet}, 16'h1234);
    for (int p = 0; p < 8; p++) begin
      v = 6'h30 | 6'((p * 3) & 15);
      apb(1'b1, 12'h020 + 12'(4 * p), {26'h0, v});
    end
    settle();
    `PISC_CHK(port_cell_mode, 8'hAA);
    `PISC_CHK(port_unstructured, 8'h44);
    `PISC_CHK(port_structured, 8'h11);
    `PISC_CHK({port_adaptive, port_timestamp}, 16'hB438);
    `PISC_CHK({port_tx_active, port_rx_active}, 16'hFFFF);
    apb(1'b1, 12'h400, 32'h092F5FF1);
    apb(1'b1, 12'h800, 32'h0B824E01);
    apb(1'b1, 12'hC00, 32'h02001003);
    apb(1'b1, 12'h404, 32'h00000002);
    apb(1'b1, 12'h408, 32'h00000000);
    settle();
    `PISC_CHK({rx_slot_live, tx_slot_live, rx_ref_entry}, 34'h0);
    apb(1'b1, 12'h800, 32'h0B824E03);
    apb(1'b1, 12'h400, 32'h092F5FF3);
    settle();
    `PISC_CHK({rx_slot_live, tx_slot_live, rx_ref_entry}, {2'h3, 32'h092F5FF3});
    `PISC_CHK({following_slot_index, decorrelator_seed, cell_fill_count}, {5'd1, 5'd15, 6'd47});
    `PISC_CHK({seq_number_check_en, seq_fast_algorithm, structure_sync_loss_limit}, 4'hC);
    `PISC_CHK({starvation_count, logical_buffer_size}, {11'd512, 14'd1024});
    `PISC_CHK(tx_ext_entry, 32'h02001003);
    `PISC_CHK({reinit_on_overflow, reinit_on_underflow, payload_scramble_en}, 3'h6);
    lookup_slot <= 5'd1;
    settle();
    `PISC_CHK({rx_slot_live, rx_ref_entry}, {1'b1, 32'h092F5FF3});
    lookup_slot <= 5'd2;
    settle();
    `PISC_CHK({rx_slot_live, decorrelator_seed}, 6'h00);
    apb(1'b1, 12'h484, 32'h000000DB);
    apb(1'b1, 12'h884, 32'h0000000B);
    lookup_port <= 3'd1;
    lookup_slot <= 5'd1;
    settle();
    `PISC_CHK({payload_descramble_en, ocd_start_irq_en, ocd_end_irq_en}, 3'h7);
    `PISC_CHK({hunt_force, idle_delete_en, payload_scramble_en}, 3'h3);
    `PISC_CHK(cell_fill_count, 6'h00);
    apb(1'b1, 12'h004, 32'h0);
    settle();
    `PISC_CHK({rx_slot_live, tx_slot_live, payload_scramble_en}, 3'h0);
    ext_word <= 32'h80000003;
    settle();
    `PISC_CHK({threshold_active, threshold_value}, 17'h10003);
    ext_word <= 32'h00000010;
    settle();
    `PISC_CHK({timer_enable, timer_value}, 17'h00010);
    n_tick = 8'h00;
    repeat (50) begin
      @(posedge pclk);
      if (oam_tick === 1'b1) n_tick++;
    end
    `PISC_CHK(n_tick, 8'd5);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h484, 32'h0);
    `PISC_CHK(rd_q, 32'h000000DB);
    foreach (dflt[i]) begin
      apb(1'b0, dflt[i][43:32], 32'h0);
      `PISC_CHK(rd_q, dflt[i][31:0]);
    end
    apb(1'b1, 12'h900, 32'h00010001);
    apb(1'b1, 12'h904, 32'h00010000);
    settle();
    `PISC_CHK(reinit_seen, 8'h04);
    print_verdict();
  end
endmodule
`default_nettype wire
